/* hdl/wspc_controller.sv */
// Purpose: Wake/sleep power controller with Wishbone register access
// Assumes: clk at 20 MHz, nrst synchronous active low, one role per device
// Notes: Registers sit at word index times four; ack comes one cycle after request
//
// What this block does
// - Wake on enabled pin change or sleep timer
// - Pin change starts wake and relink attempt
// - Transmitter pin wake needs mode bit 5
// - Receiver: four pins, own enables bits 0-3
// - Receiver timer bit 4 overrides pin wake
// - Seek for wake time, then sleep if down
// - Pin wake window: (ext+1)*count*10 ms
// - Timer mode cycles sleep and wake
// - Sixteen-bit sleep, eight-bit wake, 10 ms units
// - Sleep timer beats relink; both must wake
// - Each role keeps its own timers
// - Zero wake count prevents return to sleep
// - Sleep counts held as low/high byte pairs
// - Receiver sleep count used in timer mode and as link-loss time
// - After auto sleep, use configured wake mode
// - Wake interrupt self-clearing, tracks awake state
// - Power down bits: receiver 7, transmitter 6
// - Link loss for sleep count triggers sleep
// - Interrupt config bit 1 selects wake interrupt
`timescale 1ns/1ps
`default_nettype none
module wspc_controller
  import wspc_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Wake pins
  input wire logic transmitter_wake_pin,
  input wire logic [3:0] receiver_digital_inputs,
  // Link status from the radio
  input wire logic linkUp,
  // Other interrupt request from the rest of the device
  input wire logic otherIrq,
  // Power and interrupt outputs
  output logic powerDown,
  output logic irqPin
);
  // Registers
  logic [7:0] rx_wake_source_enable;
  logic [15:0] rx_sleep_count;
  logic [15:0] tx_sleep_count;
  logic [7:0] rx_wake_window_count;
  logic [7:0] tx_wake_window_count;
  logic [7:0] rx_wake_window_extension;
  logic [7:0] tx_wake_window_extension;
  logic [7:0] interrupt_config;
  logic [7:0] transmitter_mode_reg;
  logic [7:0] rx_mode_reg;
  logic [7:0] ctrlReg;
  // State
  wspc_state_t state;
  logic [15:0] sleepCnt;
  logic [15:0] winCnt;
  logic [7:0] extCnt;
  logic [15:0] lossCnt;
  logic pinWoke;
  logic [4:0] pinMeta, pinSync, pinPrev;
  wspc_tick_if tk ();

  wspc_prescaler #(.PERIOD(TICK_PERIOD)) u_pre (
    .clk(clk),
    .nrst(nrst),
    .tk(tk)
  );

  // Role-muxed view of configuration
  logic roleRx;
  logic pdBit;
  logic timerMode;
  logic [15:0] sleepVal;
  logic [7:0] winVal;
  logic [7:0] extVal;
  logic pinEvent;
  logic [4:0] pinChg;
  assign roleRx = ctrlReg[CTRL_ROLE_BIT];
  assign pdBit = roleRx ? rx_mode_reg[RX_MODE_PD_BIT]
                        : transmitter_mode_reg[TX_MODE_PD_BIT];
  assign timerMode = roleRx ? rx_wake_source_enable[RX_WAKE_TIMER_BIT]
                            : !transmitter_mode_reg[TX_MODE_PINWAKE_BIT];
  assign sleepVal = roleRx ? rx_sleep_count : tx_sleep_count;
  assign winVal = roleRx ? rx_wake_window_count : tx_wake_window_count;
  assign extVal = roleRx ? rx_wake_window_extension : tx_wake_window_extension;
  assign pinChg = pinSync ^ pinPrev;
  // Pin wake only with timer wake off
  assign pinEvent = roleRx
      ? (!rx_wake_source_enable[RX_WAKE_TIMER_BIT]
         && |(pinChg[3:0] & rx_wake_source_enable[3:0]))
      : (transmitter_mode_reg[TX_MODE_PINWAKE_BIT] && pinChg[4]);

  // Two-stage pin synchroniser and change detector
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pinMeta <= 5'h00;
      pinSync <= 5'h00;
      pinPrev <= 5'h00;
    end else begin
      pinMeta <= {transmitter_wake_pin, receiver_digital_inputs};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // Wishbone decode
  logic hit;
  logic [7:0] idx;
  logic req;
  assign idx = adr_i[9:2];
  assign req = cyc_i && stb_i && !ack_o;

  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    case (a)
      IDX_RX_WAKE: rd_reg = rx_wake_source_enable;
      IDX_RX_SLEEP_LO: rd_reg = rx_sleep_count[7:0];
      IDX_RX_SLEEP_HI: rd_reg = rx_sleep_count[15:8];
      IDX_RX_WIN: rd_reg = rx_wake_window_count;
      IDX_RX_EXT: rd_reg = rx_wake_window_extension;
      IDX_TX_EXT: rd_reg = tx_wake_window_extension;
      IDX_TX_SLEEP_LO: rd_reg = tx_sleep_count[7:0];
      IDX_TX_SLEEP_HI: rd_reg = tx_sleep_count[15:8];
      IDX_TX_WIN: rd_reg = tx_wake_window_count;
      IDX_INT_CFG: rd_reg = interrupt_config;
      IDX_TX_MODE: rd_reg = transmitter_mode_reg;
      IDX_RX_MODE: rd_reg = rx_mode_reg;
      IDX_CTRL: rd_reg = ctrlReg;
      IDX_STATUS: rd_reg = {5'h00, pinWoke, state};
      default: rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  // Bus answer: one cycle ack, unmapped reads zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= req ? {24'h00_0000, rd_reg(idx)} : 32'h0000_0000;
    end
  end

  // Register writes on lane 0
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_wake_source_enable <= REG_RESET;
      rx_sleep_count <= 16'h0000;
      tx_sleep_count <= 16'h0000;
      rx_wake_window_count <= REG_RESET;
      tx_wake_window_count <= REG_RESET;
      rx_wake_window_extension <= REG_RESET;
      tx_wake_window_extension <= REG_RESET;
      interrupt_config <= REG_RESET;
      transmitter_mode_reg <= REG_RESET;
      rx_mode_reg <= REG_RESET;
      ctrlReg <= REG_RESET;
    end else if (req && we_i && sel_i[0]) begin
      case (idx)
        IDX_RX_WAKE: rx_wake_source_enable <= dat_i[7:0] & RX_WAKE_WMASK;
        IDX_RX_SLEEP_LO: rx_sleep_count[7:0] <= dat_i[7:0];
        IDX_RX_SLEEP_HI: rx_sleep_count[15:8] <= dat_i[7:0];
        IDX_RX_WIN: rx_wake_window_count <= dat_i[7:0];
        IDX_RX_EXT: rx_wake_window_extension <= dat_i[7:0];
        IDX_TX_EXT: tx_wake_window_extension <= dat_i[7:0];
        IDX_TX_SLEEP_LO: tx_sleep_count[7:0] <= dat_i[7:0];
        IDX_TX_SLEEP_HI: tx_sleep_count[15:8] <= dat_i[7:0];
        IDX_TX_WIN: tx_wake_window_count <= dat_i[7:0];
        IDX_INT_CFG: interrupt_config <= dat_i[7:0] & 8'hfe;
        IDX_TX_MODE: transmitter_mode_reg <= dat_i[7:0];
        IDX_RX_MODE: rx_mode_reg <= dat_i[7:0];
        IDX_CTRL: ctrlReg <= {6'h00, dat_i[1:0]};
        default: ;
      endcase
    end
  end

  // Power state machine, counting 10 ms ticks
  logic winDone;
  assign winDone = (winCnt == 16'h0000) && (extCnt == 8'h00);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= WSPC_AWAKE;
      sleepCnt <= 16'h0000;
      winCnt <= 16'h0000;
      extCnt <= 8'h00;
      lossCnt <= 16'h0000;
      pinWoke <= 1'b0;
    end else begin
      case (state)
        WSPC_AWAKE: begin
          // Link loss watchdog
          // Watch off or link present keeps the loss timer full
          if (!ctrlReg[CTRL_LINK_BIT] || linkUp) begin
            lossCnt <= sleepVal;
          end else if (tk.tick && winVal != 8'h00) begin
            if (lossCnt == 16'h0000) begin
              state <= WSPC_SLEEP;
              sleepCnt <= sleepVal;
            end else begin
              lossCnt <= lossCnt - 16'h0001;
            end
          end
          // Host power-down request
          if (pdBit && winVal != 8'h00) begin
            state <= WSPC_SLEEP;
            sleepCnt <= sleepVal;
          end
        end
        WSPC_SLEEP: begin
          if (pinEvent) begin
            state <= WSPC_SEEK;
            pinWoke <= 1'b1;
            winCnt <= {8'h00, winVal};
            extCnt <= extVal;
          end else if (timerMode && tk.tick) begin
            if (sleepCnt <= 16'h0001) begin
              state <= WSPC_SEEK;
              pinWoke <= 1'b0;
              winCnt <= {8'h00, winVal};
              extCnt <= 8'h00;
            end else begin
              sleepCnt <= sleepCnt - 16'h0001;
            end
          end
        end
        WSPC_SEEK: begin
          // Window end wins over relink while still down
          if (tk.tick && winVal != 8'h00) begin
            if (winCnt <= 16'h0001 && extCnt == 8'h00) begin
              if (pdBit || !linkUp) begin
                state <= WSPC_SLEEP;
                sleepCnt <= sleepVal;
              end else begin
                state <= WSPC_AWAKE;
                lossCnt <= sleepVal;
              end
            end else if (winCnt <= 16'h0001) begin
              winCnt <= {8'h00, winVal};
              extCnt <= extCnt - 8'h01;
            end else begin
              winCnt <= winCnt - 16'h0001;
            end
          end else if (winVal == 8'h00 || winDone) begin
            state <= WSPC_AWAKE;
            lossCnt <= sleepVal;
          end
        end
        default: state <= WSPC_AWAKE;
      endcase
    end
  end

  // Outputs from flip-flops; wake interrupt tracks awake state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      powerDown <= 1'b0;
      irqPin <= 1'b0;
    end else begin
      powerDown <= (state == WSPC_SLEEP);
      if (interrupt_config[INT_CFG_WAKE_BIT]) begin
        irqPin <= interrupt_config[INT_CFG_POL_BIT] ~^ (state != WSPC_SLEEP);
      end else begin
        irqPin <= interrupt_config[INT_CFG_POL_BIT] ~^ otherIrq;
      end
    end
  end
endmodule : wspc_controller
`default_nettype wire

/* hdl/wspc_pkg.sv */
// Purpose: Constants for the wake/sleep power controller
// Assumes: Byte-wide registers on a 32-bit classic Wishbone bus
// Notes: Register word index times four gives the byte address
package wspc_pkg;
  // Register indices
  localparam logic [7:0] IDX_RX_WAKE = 8'h45;
  localparam logic [7:0] IDX_RX_SLEEP_LO = 8'h46;
  localparam logic [7:0] IDX_RX_SLEEP_HI = 8'h47;
  localparam logic [7:0] IDX_RX_WIN = 8'h48;
  localparam logic [7:0] IDX_RX_EXT = 8'h4c;
  localparam logic [7:0] IDX_TX_EXT = 8'h4d;
  localparam logic [7:0] IDX_TX_SLEEP_LO = 8'h57;
  localparam logic [7:0] IDX_TX_SLEEP_HI = 8'h58;
  localparam logic [7:0] IDX_TX_WIN = 8'h59;
  localparam logic [7:0] IDX_INT_CFG = 8'h53;
  localparam logic [7:0] IDX_TX_MODE = 8'h60;
  localparam logic [7:0] IDX_RX_MODE = 8'h61;
  localparam logic [7:0] IDX_CTRL = 8'h62;
  localparam logic [7:0] IDX_STATUS = 8'h63;
  // Field positions
  localparam int TX_MODE_PD_BIT = 6;
  localparam int TX_MODE_PINWAKE_BIT = 5;
  localparam int RX_MODE_PD_BIT = 7;
  localparam int RX_WAKE_TIMER_BIT = 4;
  localparam int INT_CFG_WAKE_BIT = 1;
  localparam int INT_CFG_POL_BIT = 7;
  localparam int CTRL_ROLE_BIT = 0;
  localparam int CTRL_LINK_BIT = 1;
  // Reset value and wake register write mask
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RX_WAKE_WMASK = 8'h1f;
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 18;
  // Power states
  typedef enum logic [1:0] {
    WSPC_AWAKE = 2'b00,
    WSPC_SEEK = 2'b01,
    WSPC_SLEEP = 2'b10
  } wspc_state_t;
endpackage : wspc_pkg

/* hdl/wspc_prescaler.sv */
// Purpose: Derives the 10 ms tick from the system clock
// Assumes: clk at 20 MHz, nrst synchronous active low
// Notes: Period is a parameter so a bench may shorten it
`timescale 1ns/1ps
`default_nettype none
module wspc_prescaler
  import wspc_pkg::*;
#(
  parameter int PERIOD = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Tick out
  wspc_tick_if.src tk
);
  logic [TICK_W-1:0] cnt;

  // Free-running divider
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= '0;
      tk.tick <= 1'b0;
    end else if (cnt == TICK_W'(PERIOD - 1)) begin
      cnt <= '0;
      tk.tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tk.tick <= 1'b0;
    end
  end
endmodule : wspc_prescaler
`default_nettype wire

/* hdl/wspc_tick_if.sv */
// Purpose: Carries the 10 ms tick between prescaler and controller
// Assumes: Single clock domain
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface wspc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : wspc_tick_if
`default_nettype wire

/* testbench/wspc_chk.sv */
// Purpose: Port checks for the wake/sleep power controller
// Assumes: Interrupt config is shadowed from bus writes seen at the ack edge
// Notes: Bound below to every controller instance
`timescale 1ns/1ps
`default_nettype none
module wspc_chk
  import wspc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins and status
  input wire logic transmitter_wake_pin,
  input wire logic [3:0] receiver_digital_inputs,
  input wire logic linkUp,
  input wire logic otherIrq,
  input wire logic powerDown,
  input wire logic irqPin
);
  logic [7:0] cfg;
  logic rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadow of the interrupt config, updated one cycle after the write lands
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg <= REG_RESET;
    end else if (ack_o && we_i && sel_i[0] && adr_i[9:2] == IDX_INT_CFG) begin
      cfg <= dat_i[7:0];
    end
  end
  // Read answer under way
  assign rd = ack_o && !we_i;
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("stray ack");
  read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits set");
  wake_reserved_a: assert property (rd && adr_i[9:2] == IDX_RX_WAKE |-> dat_o[7:5] == 3'h0)
    else $error("reserved wake bits read back");
  cfg_bit0_a: assert property (rd && adr_i[9:2] == IDX_INT_CFG |-> !dat_o[0])
    else $error("config bit 0 read back");
  irq_sleep_a: assert property (cfg[INT_CFG_WAKE_BIT] && $stable(cfg) && powerDown
    && $past(powerDown) |-> irqPin == !cfg[INT_CFG_POL_BIT]) else $error("irq active asleep");
  irq_awake_a: assert property (cfg[INT_CFG_WAKE_BIT] && $stable(cfg) && !powerDown
    && !$past(powerDown) |-> irqPin == cfg[INT_CFG_POL_BIT]) else $error("irq idle awake");
  // Main flows reached
  cover property ($rose(powerDown));
  cover property ($fell(powerDown));
  cover property (rd && adr_i[9:2] == IDX_RX_WAKE);
endmodule : wspc_chk
bind wspc_controller wspc_chk wspc_chk_i (.clk, .nrst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .transmitter_wake_pin, .receiver_digital_inputs, .linkUp, .otherIrq,
  .powerDown, .irqPin);
`default_nettype wire

/* testbench/wspc_controller_bench.sv */
// Purpose: Self-checking bench for the wake/sleep power controller
// Assumes: Tick shortened to TP cycles
// Notes: Receiver timer, pin and relink flows, then transmitter pin wake
`timescale 1ns/1ps
`default_nettype none
module wspc_controller_bench import wspc_pkg::*;;
  localparam int TP = 20;
  localparam logic [7:0] RW [8] = '{IDX_RX_SLEEP_LO, IDX_RX_SLEEP_HI, IDX_RX_WIN, IDX_RX_EXT,
    IDX_TX_EXT, IDX_TX_SLEEP_LO, IDX_TX_SLEEP_HI, IDX_TX_WIN};
  logic clk = 1'h0;
  logic nrst;
  logic cyc_i;
  logic stb_i;
  logic we_i;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [3:0] selv = 4'h1;
  logic [31:0] dat_i;
  logic otherIrq;
  logic [31:0] dat_o;
  logic ack_o;
  logic txPin;
  logic link;
  logic powerDown;
  logic irqPin;
  logic [3:0] rxPins;
  int err_total = 0;
  int comparisons = 0;
  always #25 clk = !clk;
  wspc_controller #(.TICK_PERIOD(TP)) wspc_controller_i (.clk, .nrst, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .transmitter_wake_pin(txPin),
    .receiver_digital_inputs(rxPins), .linkUp(link), .otherIrq, .powerDown, .irqPin);
  wspc_peer wspc_peer_i (.clk, .txPin, .rxPins, .link);
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic Wishbone cycle, request held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= {idx, 2'h0};
    sel_i <= selv;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    chk("ack", 32'h1, ack_o);
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, idx, d, q);
  endtask : wr
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, idx, 8'h0, q);
    chk("read", e, q);
  endtask : rchk
  // Wait, bounded, for powerDown to reach v
  task automatic waitPd(input logic v, input int lim, output int n);
    n = 0;
    while (powerDown !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : waitPd
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    results();
  end
  // Test sequence
  initial begin
    int n;
    nrst <= 1'h0;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i <= 1'h0;
    adr_i <= 10'h000;
    sel_i <= 4'h0;
    dat_i <= 32'h0;
    otherIrq <= 1'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    chk("powerDown", 32'h0, powerDown);
    foreach (RW[i]) begin
      rchk(RW[i], {24'h0, REG_RESET});
      wr(RW[i], 8'ha5 ^ 8'(i));
      rchk(RW[i], {24'h0, 8'ha5 ^ 8'(i)});
    end
    wr(IDX_RX_WAKE, 8'hff);
    rchk(IDX_RX_WAKE, 32'h1f);
    rchk(8'h70, 32'h0);
    // Lane 0 disabled: write must be ignored
    selv = 4'he;
    wr(IDX_TX_EXT, 8'h00);
    selv = 4'h1;
    rchk(IDX_TX_EXT, 32'ha1);
    wr(IDX_STATUS, 8'hff);
    rchk(IDX_STATUS, 32'h0);
    // Receiver in timer mode, wake interrupt active high, other source ignored
    wr(IDX_CTRL, 8'h01);
    wr(IDX_INT_CFG, 8'h82);
    otherIrq <= 1'h1;
    wr(IDX_RX_WAKE, 8'h14);
    wr(IDX_RX_SLEEP_LO, 8'h03);
    wr(IDX_RX_SLEEP_HI, 8'h00);
    wr(IDX_RX_WIN, 8'h02);
    wr(IDX_RX_EXT, 8'h05);
    wr(IDX_RX_MODE, 8'h80);
    waitPd(1'h1, 20, n);
    chk("irq asleep", 32'h0, irqPin);
    wspc_peer_i.flip(2);
    repeat (8) @(posedge clk);
    chk("timer over pin", 32'h1, powerDown);
    waitPd(1'h0, 4 * TP, n);
    chk("sleep length", 32'h1, n >= TP);
    chk("timer wake", 32'h0, powerDown);
    chk("irq awake", 32'h1, irqPin);
    rchk(IDX_STATUS, 32'h1);
    waitPd(1'h1, 3 * TP, n);
    chk("timer window", 32'h1, powerDown);
    waitPd(1'h0, 4 * TP, n);
    wr(IDX_RX_WIN, 8'h00);
    waitPd(1'h1, 4 * TP, n);
    chk("zero count", 32'h0, powerDown);
    // Receiver pin wake with window of count times three
    wr(IDX_RX_WAKE, 8'h04);
    wr(IDX_RX_WIN, 8'h02);
    wr(IDX_RX_EXT, 8'h02);
    wr(IDX_RX_MODE, 8'h80);
    waitPd(1'h1, 20, n);
    wspc_peer_i.flip(1);
    repeat (5 * TP) @(posedge clk);
    chk("disabled pin", 32'h1, powerDown);
    wspc_peer_i.flip(2);
    waitPd(1'h0, 10, n);
    chk("pin wake", 32'h0, powerDown);
    rchk(IDX_STATUS, 32'h5);
    // Four ticks would be over here, six are not
    repeat (4 * TP) @(posedge clk);
    chk("extended window", 32'h0, powerDown);
    waitPd(1'h1, 3 * TP, n);
    chk("window end", 32'h1, powerDown);
    // Relink with power down cleared and wake window count zeroed
    wspc_peer_i.flip(2);
    waitPd(1'h0, 10, n);
    wspc_peer_i.setLink(1'h1);
    wr(IDX_RX_MODE, 8'h00);
    wr(IDX_RX_WIN, 8'h00);
    repeat (6 * TP) @(posedge clk);
    chk("relinked", 32'h0, powerDown);
    // Link watch on: losing the link for the sleep count powers down
    wr(IDX_CTRL, 8'h03);
    wr(IDX_RX_WIN, 8'h01);
    wspc_peer_i.setLink(1'h0);
    repeat (2 * TP) @(posedge clk);
    chk("link held", 32'h0, powerDown);
    waitPd(1'h1, 3 * TP, n);
    chk("link loss", 32'h1, powerDown);
    // Transmitter role wakes on its own pin only
    wr(IDX_TX_WIN, 8'h01);
    wr(IDX_TX_MODE, 8'h60);
    wr(IDX_CTRL, 8'h00);
    waitPd(1'h1, 20, n);
    chk("tx asleep", 32'h1, powerDown);
    wspc_peer_i.flip(2);
    repeat (3 * TP) @(posedge clk);
    chk("other role pin", 32'h1, powerDown);
    wspc_peer_i.flip(4);
    waitPd(1'h0, 10, n);
    chk("tx pin wake", 32'h0, powerDown);
    // Wake interrupt off: other source reaches the pin, active low
    wr(IDX_INT_CFG, 8'h00);
    chk("other irq on", 32'h0, irqPin);
    otherIrq <= 1'h0;
    repeat (2) @(posedge clk);
    chk("other irq off", 32'h1, irqPin);
    results();
  end
endmodule : wspc_controller_bench
`default_nettype wire

/* testbench/wspc_peer.sv */
// Purpose: Far side model: wake sources and the radio peer
// Assumes: Changes land just after a rising edge
// Notes: HOLD stands in for the minimum pin hold at the shortened tick
`timescale 1ns/1ps
`default_nettype none
module wspc_peer #(
  parameter int HOLD = 4
) (
  // Clock
  input wire logic clk,
  // Wake pins and link
  output logic txPin,
  output logic [3:0] rxPins,
  output logic link
);
  // Quiet levels at start
  initial begin
    txPin = 1'h0;
    rxPins = 4'h0;
    link = 1'h0;
  end
  // Flip one pin, 4 being the transmitter pin, then hold the new level
  task automatic flip(input int idx);
    if (idx == 4) begin
      txPin <= !txPin;
    end else begin
      rxPins <= rxPins ^ (4'h1 << idx);
    end
    repeat (HOLD) @(posedge clk);
  endtask : flip
  // Peer found or lost
  task automatic setLink(input logic v);
    link <= v;
  endtask : setLink
endmodule : wspc_peer
`default_nettype wire
